// [psm_pins.sv]
// strap latching and mii pin logic of the transceiver
//
// Implementation choices: the address-and-strobe port and the register offsets.
module psm_pins
	import psm_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RESET_N,
	// reference clock pins
	input wire logic REF_CLK_IN,
	input wire logic REF_MODE_CLOCK,
	output logic CRYSTAL_DRIVE_O,
	output logic CRYSTAL_DRIVE_OE,
	// mii receive pins, shared with straps
	input wire psm_rxpin_s RX_PIN_I,
	output psm_rxpin_s RX_PIN_O,
	output psm_rxpin_s RX_PIN_OE,
	output logic CRS,
	output logic COL,
	// mii transmit pins
	input wire logic TXCLK_I,
	output logic TXCLK_O,
	output logic TXCLK_OE,
	input wire psm_tx_s TX_PIN,
	// indicator pins, shared with address straps
	input wire logic [1:0] LED_I,
	output logic [1:0] LED_O,
	output logic [1:0] LED_OE,
	// management pins
	input wire logic MDC,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE,
	// interrupt pin
	output logic INT_O,
	// core side
	input wire psm_rx_s CORE_RX,
	input wire logic CORE_CRS,
	input wire logic CORE_COL,
	input wire logic CORE_LINK,
	input wire logic CORE_SPEED100,
	input wire logic [8:0] CORE_EVENTS,
	input wire psm_mgmt_s CORE_MGMT,
	output logic RX_TAKE,
	output psm_tx_s TX_NIBBLE,
	output logic TX_NIBBLE_VALID,
	output logic MGMT_BIT_VALID,
	output logic MGMT_BIT,
	output psm_strap_s STRAPS,
	output logic HW_RESET,
	output logic ISOLATE,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);

	// ==========================================
	// input synchronisers
	logic [PSM_SYNC_W-1:0] async_in; // all pin levels from outside
	logic [PSM_SYNC_W-1:0] sync_out; // same, two flops later
	psm_rxpin_s rxpin_s; // synced receive pins
	psm_tx_s tx_s; // synced transmit pins
	logic txclk_s, rst_n_s, mdc_s, mdio_s, ref_s, refmode_s;
	logic [1:0] led_s;

	assign async_in = {RX_PIN_I, TXCLK_I, LED_I, RESET_N, MDC, MDIO_I,
		REF_CLK_IN, REF_MODE_CLOCK, TX_PIN};
	assign {rxpin_s, txclk_s, led_s, rst_n_s, mdc_s, mdio_s, ref_s, refmode_s,
		tx_s} = sync_out;

	psm_sync #(.W(PSM_SYNC_W)) u_sync (
		.clk(CLOCK),
		.d(async_in),
		.q(sync_out)
	);

	// ==========================================
	// reset and strap latching
	logic hw_rst; // system reset or reset pin low
	psm_strap_s strap_q; // latched straps
	logic drive_q; // pin drivers enabled
	logic isolate_q; // live receiver isolation

	assign hw_rst = SYS_RST | ~rst_n_s;

	// sample straps all through reset, last value holds after release
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			strap_q.auto_crossover_enable <= rxpin_s.rxd[3];
			strap_q.phy_addr <= {rxpin_s.rxd[2], 1'b0, led_s};
			strap_q.rx_tristate_strap <= rxpin_s.rxd[1];
			strap_q.duplex_strap <= rxpin_s.rxd[0];
			strap_q.autoneg_strap <= rxpin_s.rxclk;
			strap_q.node_select_strap <= rxpin_s.rxer;
			strap_q.speed_strap <= txclk_s;
		end
	end

	// drivers stay off in reset, on from the first edge after release
	always_ff @(posedge CLOCK) begin
		drive_q <= ~hw_rst;
	end

	// indicator 1 pin turns into the isolation input when strapped so
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			isolate_q <= 1'b0;
		end else begin
			isolate_q <= strap_q.rx_tristate_strap & led_s[1];
		end
	end

	// ==========================================
	// mii clock generation from the reference
	logic ref_prev_q; // reference level one cycle back
	logic [2:0] div_q; // reference edges within a half period
	logic slow_clk_q; // 2.5 MHz clock for 10M
	logic mclk_d, mclk_q; // selected mii clock
	logic speed100; // active speed
	logic mclk_rise, mclk_fall;

	assign speed100 = strap_q.autoneg_strap ? CORE_SPEED100 : strap_q.speed_strap;
	assign mclk_d = speed100 ? ref_s : slow_clk_q;
	assign mclk_rise = mclk_d & ~mclk_q;
	assign mclk_fall = ~mclk_d & mclk_q;

	// divide reference edges by ten for the slow clock
	always_ff @(posedge CLOCK) begin
		ref_prev_q <= ref_s;
		if (hw_rst) begin
			div_q <= 3'h0;
			slow_clk_q <= 1'b0;
		end else if (ref_s & ~ref_prev_q) begin
			if (div_q == PSM_HALF_DIV) begin
				div_q <= 3'h0;
				slow_clk_q <= ~slow_clk_q;
			end else begin
				div_q <= div_q + 3'h1;
			end
		end
	end

	// registered mii clock
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			mclk_q <= 1'b0;
		end else begin
			mclk_q <= mclk_d;
		end
	end

	// crystal drive is the inverted reference, floating for an external clock
	always_ff @(posedge CLOCK) begin
		CRYSTAL_DRIVE_O <= ~ref_s;
		CRYSTAL_DRIVE_OE <= ~refmode_s;
	end

	// ==========================================
	// receive path, launched on the falling mii clock
	psm_rx_s rx_q; // nibble on the pins
	logic rx_take_q;

	// new nibble each falling edge, zero when not valid
	always_ff @(posedge CLOCK) begin
		rx_take_q <= 1'b0;
		if (hw_rst) begin
			rx_q <= '0;
		end else if (mclk_fall) begin
			rx_take_q <= 1'b1;
			rx_q.dv <= CORE_RX.dv;
			rx_q.er <= CORE_RX.er;
			rx_q.rxd <= CORE_RX.dv ? CORE_RX.rxd : 4'h0;
		end
	end

	// receive pin levels and enables
	always_ff @(posedge CLOCK) begin
		RX_PIN_O <= {mclk_d, rx_q.er, rx_q.dv, rx_q.rxd};
		CRS <= drive_q & CORE_CRS;
		COL <= drive_q & CORE_COL;
		if (~drive_q | isolate_q) begin
			RX_PIN_OE <= '0;
		end else begin
			RX_PIN_OE <= '1;
		end
		TXCLK_O <= mclk_d;
		TXCLK_OE <= drive_q;
	end

	// ==========================================
	// transmit path, sampled on the rising mii clock
	always_ff @(posedge CLOCK) begin
		TX_NIBBLE_VALID <= 1'b0;
		if (hw_rst) begin
			TX_NIBBLE <= '0;
		end else if (mclk_rise & tx_s.txen) begin
			TX_NIBBLE <= tx_s;
			TX_NIBBLE_VALID <= 1'b1;
		end
	end

	// ==========================================
	// management pins
	logic mdc_prev_q;

	// one bit per rising management clock, drive as the core asks
	always_ff @(posedge CLOCK) begin
		mdc_prev_q <= mdc_s;
		MGMT_BIT_VALID <= ~hw_rst & mdc_s & ~mdc_prev_q;
		MGMT_BIT <= mdio_s;
		MDIO_O <= CORE_MGMT.bit_v;
		MDIO_OE <= drive_q & CORE_MGMT.en;
	end

	// ==========================================
	// registers
	logic [8:0] int_sel_q; // events allowed onto the interrupt
	logic [3:0] led_sel_q; // indicator functions
	logic [8:0] event_q; // sticky events
	logic [8:0] evt_clr;

	assign evt_clr = (REG_WR && REG_ADDR == PSM_REG_EVENT) ? REG_WDATA[8:0] : 9'h000;

	// control registers
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			int_sel_q <= PSM_INT_SEL_RST;
			led_sel_q <= PSM_LED_SEL_RST;
		end else if (REG_WR) begin
			case (REG_ADDR)
				PSM_REG_INT_SEL: int_sel_q <= REG_WDATA[8:0];
				PSM_REG_LED_SEL: led_sel_q <= REG_WDATA[3:0];
				default: ;
			endcase
		end
	end

	// sticky events, a new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			event_q <= 9'h000;
		end else begin
			event_q <= (event_q & ~evt_clr) | CORE_EVENTS;
		end
	end

	// read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge CLOCK) begin
		if (hw_rst | ~REG_RD) begin
			REG_RDATA <= 32'h0000_0000;
		end else begin
			case (REG_ADDR)
				PSM_REG_INT_SEL: REG_RDATA <= {23'h000000, int_sel_q};
				PSM_REG_LED_SEL: REG_RDATA <= {28'h0000000, led_sel_q};
				PSM_REG_EVENT: REG_RDATA <= {23'h000000, event_q};
				PSM_REG_STRAP: REG_RDATA <= {22'h000000, strap_q};
				default: REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

	// interrupt on any selected sticky event
	always_ff @(posedge CLOCK) begin
		if (hw_rst) begin
			INT_O <= 1'b0;
		end else begin
			INT_O <= |(event_q & int_sel_q);
		end
	end

	// ==========================================
	// indicators
	logic [1:0] led_val;

	// chosen function per indicator
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_led
			psm_led_e sel;
			assign sel = psm_led_e'(led_sel_q[g*PSM_LED1_SEL_LSB +: 2]);
			always_comb begin
				case (sel)
					PSM_LED_ACTIVITY: led_val[g] = CORE_CRS;
					PSM_LED_SPEED: led_val[g] = speed100;
					PSM_LED_LINK: led_val[g] = CORE_LINK;
					PSM_LED_COLLISION: led_val[g] = CORE_COL;
					default: led_val[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// indicator 1 is released when it serves as the isolation input
	always_ff @(posedge CLOCK) begin
		LED_O <= led_val;
		LED_OE[0] <= drive_q;
		LED_OE[1] <= drive_q & ~strap_q.rx_tristate_strap;
	end

	// ==========================================
	// status outputs
	always_ff @(posedge CLOCK) begin
		STRAPS <= strap_q;
		HW_RESET <= hw_rst;
		ISOLATE <= isolate_q;
		RX_TAKE <= rx_take_q;
	end

endmodule : psm_pins

// [psm_pkg.sv]
// shared constants, register map and carrier types for the strap and mii pin block
package psm_pkg;

	// ==========================================
	// register map of the plain register port
	localparam int PSM_ADDR_W = 8;
	localparam int PSM_DATA_W = 32;
	localparam logic [7:0] PSM_REG_INT_SEL = 8'h00; // interrupt event select
	localparam logic [7:0] PSM_REG_LED_SEL = 8'h04; // indicator function select
	localparam logic [7:0] PSM_REG_EVENT = 8'h08; // sticky events, write one to clear
	localparam logic [7:0] PSM_REG_STRAP = 8'h0C; // latched strap values, read only

	// ==========================================
	// events that may raise the interrupt output
	localparam int PSM_EVT_W = 9;
	localparam int PSM_EVT_RX_ERR = 0;
	localparam int PSM_EVT_JABBER = 1;
	localparam int PSM_EVT_PAGE_RX = 2;
	localparam int PSM_EVT_PD_FAULT = 3;
	localparam int PSM_EVT_PARTNER_ACK = 4;
	localparam int PSM_EVT_LINK_CHG = 5;
	localparam int PSM_EVT_AN_DONE = 6;
	localparam int PSM_EVT_REM_FAULT = 7;
	localparam int PSM_EVT_COLLISION = 8;
	localparam logic [8:0] PSM_INT_SEL_RST = 9'h000;

	// ==========================================
	// indicator functions, two select bits per indicator
	typedef enum logic [1:0] {
		PSM_LED_ACTIVITY = 2'h0,
		PSM_LED_SPEED = 2'h1,
		PSM_LED_LINK = 2'h2,
		PSM_LED_COLLISION = 2'h3
	} psm_led_e;
	localparam logic [3:0] PSM_LED_SEL_RST = 4'h4; // indicator 0 activity, 1 speed
	localparam int PSM_LED1_SEL_LSB = 2;

	// ==========================================
	// timing
	localparam int PSM_REF_MHZ = 25; // reference clock, crystal or oscillator
	localparam int PSM_SYS_MHZ = 200; // block clock
	localparam int PSM_SLOW_DIV = 10; // 10M mii clock is the reference over ten
	localparam logic [2:0] PSM_HALF_DIV = 3'(PSM_SLOW_DIV / 2 - 1); // last count of a half
	localparam int PSM_STRAP_W = 10;
	localparam int PSM_SYNC_W = 20;

	// ==========================================
	// carriers
	typedef struct packed {
		logic rxclk; // receive clock pin
		logic rxer; // receive error pin
		logic rxdv; // receive data valid pin
		logic [3:0] rxd; // receive data pins
	} psm_rxpin_s;

	typedef struct packed {
		logic txen; // transmit enable from the mac
		logic [3:0] txd; // transmit nibble from the mac
	} psm_tx_s;

	typedef struct packed {
		logic dv; // nibble valid
		logic er; // receive error
		logic [3:0] rxd; // nibble
	} psm_rx_s;

	typedef struct packed {
		logic auto_crossover_enable;
		logic [3:0] phy_addr;
		logic rx_tristate_strap;
		logic duplex_strap;
		logic autoneg_strap;
		logic node_select_strap;
		logic speed_strap; // one is 100M
	} psm_strap_s;

	typedef struct packed {
		logic en; // drive the management data pin
		logic bit_v; // level to drive
	} psm_mgmt_s;

endpackage : psm_pkg

// [psm_sync.sv]
// two flip-flop synchroniser for a group of asynchronous levels
module psm_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk,
	// async levels in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ==========================================
	// stages
	logic [W-1:0] meta_q; // first stage, read by the second stage only

	// per bit two stages, no reset so pin levels pass during reset
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				meta_q[i] <= d[i];
				q[i] <= meta_q[i];
			end
		end
	endgenerate

endmodule : psm_sync

// [psm_pins_properties.sv]
// checker of strap, pin and register behaviour of the strap and mii pin block
module psm_pins_properties
	import psm_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic HW_RESET,
	// pins
	input wire logic REF_MODE_CLOCK,
	input wire logic CRYSTAL_DRIVE_OE,
	input wire psm_rxpin_s RX_PIN_O,
	input wire psm_rxpin_s RX_PIN_OE,
	input wire logic CRS,
	input wire logic COL,
	input wire logic TXCLK_OE,
	input wire logic [1:0] LED_OE,
	input wire logic MDIO_OE,
	input wire logic MDIO_O,
	input wire logic INT_O,
	// core side
	input wire logic CORE_CRS,
	input wire logic CORE_COL,
	input wire logic MGMT_BIT_VALID,
	input wire psm_mgmt_s CORE_MGMT,
	input wire psm_tx_s TX_NIBBLE,
	input wire logic TX_NIBBLE_VALID,
	input wire psm_strap_s STRAPS,
	input wire logic ISOLATE,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA
);
	// ==========================================
	// checks, quiet while either reset is in force, except the driver check that runs through system reset
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST || HW_RESET);

	a_oe_in_reset: assert property (disable iff (1'h0) SYS_RST [*3] |->
		RX_PIN_OE == '0 && !TXCLK_OE && LED_OE == 2'h0) else $error("driver on in reset");
	a_straps_held: assert property (!$past(HW_RESET) && !$past(HW_RESET, 2) |->
		$stable(STRAPS)) else $error("straps moved");
	a_addr_bit2: assert property (STRAPS.phy_addr[2] == 1'h0)
		else $error("address bit 2 set");
	a_rxd_blank: assert property (!RX_PIN_O.rxdv |-> RX_PIN_O.rxd == 4'h0)
		else $error("nibble without valid");
	a_tx_gated: assert property (TX_NIBBLE_VALID |-> TX_NIBBLE.txen)
		else $error("nibble taken without enable");
	a_crs_follows: assert property ($past(TXCLK_OE, 2) |-> CRS == $past(CORE_CRS))
		else $error("carrier sense wrong");
	a_xtal_float: assert property (REF_MODE_CLOCK [*5] |-> !CRYSTAL_DRIVE_OE)
		else $error("crystal drive on with oscillator");
	a_xtal_drive: assert property (!REF_MODE_CLOCK [*5] |-> CRYSTAL_DRIVE_OE)
		else $error("crystal drive off");
	a_led1_off: assert property (STRAPS.rx_tristate_strap |-> !LED_OE[1])
		else $error("indicator 1 driven");
	a_iso_blank: assert property (ISOLATE [*2] |-> RX_PIN_OE == '0)
		else $error("receive pins driven in isolation");
	a_mdio_oe: assert property (MDIO_OE |-> $past(CORE_MGMT.en))
		else $error("management pin driven unasked");
	a_col_follows: assert property ($past(TXCLK_OE, 2) |-> COL == $past(CORE_COL))
		else $error("collision wrong");
	a_mdio_level: assert property (MDIO_O == $past(CORE_MGMT.bit_v))
		else $error("management level wrong");
	a_mgmt_pulse: assert property (MGMT_BIT_VALID |=> !MGMT_BIT_VALID)
		else $error("management bit pulse too long");
	a_int_masked: assert property (REG_WR && REG_ADDR == PSM_REG_INT_SEL &&
		REG_WDATA[8:0] == 9'h0 |-> ##2 !INT_O) else $error("interrupt with no select");
	a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read");
	a_strap_rd: assert property ($past(REG_RD) && $past(REG_ADDR) == PSM_REG_STRAP |->
		REG_RDATA == {22'h0, STRAPS}) else $error("strap word wrong");
endmodule : psm_pins_properties

bind psm_pins psm_pins_properties chk_u (.*);

// [psm_mac_model.sv]
// mac partner: sends transmit nibbles on the transmit clock of the phy
module psm_mac_model
	import psm_pkg::*;
(
	// clock from the phy and traffic switch
	input wire logic txclk,
	input wire logic en,
	// transmit pins toward the phy
	output psm_tx_s tx
);
	int seed = 32'hF17D; // fixed seed of the nibble stream
	initial tx = '0;
	// new nibble after each rising clock, enable random while traffic is on
	always @(posedge txclk) begin
		tx.txen <= en & 1'($random(seed));
		tx.txd <= 4'($random(seed));
	end
endmodule : psm_mac_model

// [test_psm_pins.sv]
// self-checking bench of the strap and mii pin block
module test_psm_pins;
	import psm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// design signals, named as its ports
	logic CLOCK = 1'h0, SYS_RST = 1'h1, RESET_N = 1'h0, REF_CLK_IN = 1'h0;
	logic REF_MODE_CLOCK = 1'h0, MDC = 1'h0, CORE_CRS = 1'h0, CORE_COL = 1'h0;
	logic CORE_LINK = 1'h0, CORE_SPEED100 = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0;
	logic CRYSTAL_DRIVE_O, CRYSTAL_DRIVE_OE, CRS, COL, TXCLK_I, TXCLK_O, TXCLK_OE;
	logic MDIO_I, MDIO_O, MDIO_OE, INT_O, RX_TAKE, TX_NIBBLE_VALID, MGMT_BIT_VALID;
	logic MGMT_BIT, HW_RESET, ISOLATE;
	psm_rxpin_s RX_PIN_I, RX_PIN_O, RX_PIN_OE;
	psm_tx_s TX_PIN, TX_NIBBLE;
	logic [1:0] LED_I, LED_O, LED_OE;
	psm_rx_s CORE_RX = '0;
	logic [8:0] CORE_EVENTS = 9'h0;
	psm_mgmt_s CORE_MGMT = '0;
	psm_strap_s STRAPS;
	logic [7:0] REG_ADDR = 8'h0;
	logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
	// bench state: board straps, traffic switch, sent nibbles, counters
	psm_rxpin_s strap = '0;
	logic [1:0] led_pull = 2'h0;
	logic spd_pull = 1'h1, tx_en = 1'h0;
	logic [3:0] sent_q[$];
	int seed = 32'hF17D, n_errors = 0, num_checks = 0;

	psm_pins dut_u (.*);
	psm_mac_model mac_u (.txclk(TXCLK_O), .en(tx_en), .tx(TX_PIN));

	// ==========================================
	// clocks and pin resolution: pulls win where the design does not drive
	always #2.5 CLOCK = ~CLOCK;
	always #47 MDC = ~MDC;
	initial begin
		#1.3;
		forever #40 REF_CLK_IN = ~REF_CLK_IN;
	end
	assign RX_PIN_I = (RX_PIN_O & RX_PIN_OE) | (strap & ~RX_PIN_OE);
	assign LED_I = (LED_O & LED_OE) | (led_pull & ~LED_OE);
	assign TXCLK_I = TXCLK_OE ? TXCLK_O : spd_pull;
	assign MDIO_I = MDIO_OE ? MDIO_O : 1'h1;
	always @(posedge CLOCK) CORE_MGMT <= 2'($random(seed));

	// ==========================================
	// reference model: receive nibble held until taken, sent nibbles queued
	always @(negedge TXCLK_O) if (TX_PIN.txen === 1'h1) sent_q.push_back(TX_PIN.txd);
	always @(posedge CLOCK) begin
		if (RX_TAKE === 1'h1 && HW_RESET === 1'h0) begin
			chk("rx", {26'h0, CORE_RX.dv, CORE_RX.er, CORE_RX.dv ? CORE_RX.rxd : 4'h0},
				{26'h0, RX_PIN_O.rxdv, RX_PIN_O.rxer, RX_PIN_O.rxd});
			CORE_RX <= 6'($random(seed));
		end
		if (TX_NIBBLE_VALID === 1'h1) begin
			chk("tx", {27'h1, sent_q.size() ? sent_q.pop_front() : 4'hX},
				{27'h1, TX_NIBBLE.txd});
		end
	end

	// ==========================================
	// tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		cyc(1);
		REG_WR <= 1'h0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		cyc(1);
		REG_RD <= 1'h0;
		cyc(1);
		chk("reg", exp, REG_RDATA);
	endtask : rd
	// traffic stops, board straps set, hardware reset pulsed
	task automatic hw_reset(input logic tri_v);
		psm_rxpin_s s;
		s = 7'($random(seed));
		s.rxer = 1'h0;
		s.rxclk = tri_v;
		s.rxd[1] = tri_v;
		tx_en <= 1'h0;
		cyc(100);
		RESET_N <= 1'h0;
		strap <= s;
		spd_pull <= 1'($random(seed)); // speed strap, 10M as well as 100M
		led_pull <= 2'($random(seed));
		cyc(6);
		RESET_N <= 1'h1;
		cyc(8);
		tx_en <= 1'h1;
	endtask : hw_reset
	function automatic logic [31:0] strap_word();
		return {22'h0, strap.rxd[3], strap.rxd[2], 1'h0, led_pull, strap.rxd[1],
			strap.rxd[0], strap.rxclk, strap.rxer, spd_pull};
	endfunction : strap_word
	task automatic oe_chk(input logic p);
		logic iso;
		iso = p & led_pull[1];
		chk("oe", {22'h0, iso, p ? 2'h1 : 2'h3, iso ? 7'h00 : 7'h7F},
			{22'h0, ISOLATE, LED_OE, RX_PIN_OE});
	endtask : oe_chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// ==========================================
	// main sequence
	initial begin
		logic [2:0] r;
		logic [3:0] e;
		time t0;
		cyc(10);
		SYS_RST <= 1'h0;
		for (int p = 0; p < 2; p++) begin
			hw_reset(p[0]);
			chk("straps", strap_word(), {22'h0, STRAPS});
			rd(PSM_REG_LED_SEL, {28'h0, PSM_LED_SEL_RST});
			wr(PSM_REG_STRAP, ~strap_word());
			rd(PSM_REG_STRAP, strap_word());
			wr(8'h10, 32'hFFFFFFFF);
			rd(8'h10, 32'h0);
			oe_chk(p[0]);
			led_pull[1] <= ~led_pull[1];
			cyc(8);
			oe_chk(p[0]);
			for (int k = 0; k < PSM_EVT_W; k++) begin
				wr(PSM_REG_INT_SEL, 32'h0);
				CORE_EVENTS <= 9'h1 << k;
				cyc(1);
				CORE_EVENTS <= 9'h0;
				cyc(3);
				chk("masked int", 32'h0, {31'h0, INT_O});
				rd(PSM_REG_EVENT, 32'h1 << k);
				wr(PSM_REG_INT_SEL, 32'h1 << k);
				cyc(2);
				chk("int", 32'h1, {31'h0, INT_O});
				wr(PSM_REG_EVENT, 32'h1 << k);
				cyc(2);
				chk("cleared int", 32'h0, {31'h0, INT_O});
			end
			for (int i = 0; i < 16; i++) begin
				r = 3'($random(seed));
				e = {r[2], r[1], p[0] | spd_pull, r[0]};
				{CORE_COL, CORE_LINK, CORE_CRS} <= r;
				wr(PSM_REG_LED_SEL, 32'(i % 4));
				cyc(2);
				chk("led0", {31'h0, e[i % 4]}, {31'h0, LED_O[0]});
			end
			$display("test straps and registers %0d done", p);
		end
		@(posedge TXCLK_O);
		t0 = $time;
		@(posedge TXCLK_O);
		chk("mii clock ns", 32'h50, 32'($time - t0));
		REF_MODE_CLOCK <= 1'h1;
		cyc(6);
		chk("crystal oe", 32'h0, {31'h0, CRYSTAL_DRIVE_OE});
		$display("test clocks done");
		close_out();
	end
	// watchdog well past the expected seven hundred or so cycles
	initial begin
		cyc(20000);
		n_errors++;
		close_out();
	end
endmodule : test_psm_pins
